// ===== common/vai_defs.svh
// constants for the address-modifier select and utility interrupt block
// assumes a 25 MHz register clock and an AXI4-Lite byte address of 8 bits
`ifndef VAI_DEFS_SVH
`define VAI_DEFS_SVH

`define VAI_AW             8
// printed register indices; byte address is four times the index
`define VAI_IDX_AM_SEL     32'hfffe200d
`define VAI_IDX_VME_MASK   32'hfffe200f
`define VAI_IDX_UTIL_MASK  32'hfffe2011
`define VAI_IDX_UTIL_VEC   32'hfffe2013
// extra byte addresses for status and interrupter level
`define VAI_ADDR_STATUS    8'h50
`define VAI_ADDR_IRQ_LVL   8'h54
// register select codes
`define VAI_SEL_NONE       3'h0
`define VAI_SEL_AM         3'h1
`define VAI_SEL_VMASK      3'h2
`define VAI_SEL_UMASK      3'h3
`define VAI_SEL_VEC        3'h4
`define VAI_SEL_STATUS     3'h5
`define VAI_SEL_IRQ_LVL    3'h6
// field positions
`define VAI_AM_SRC_BIT     7
`define VAI_AM_CODE_MSB    5
`define VAI_VEC_BASE_LSB   3
// low vector bits on a plain read: the register offset
`define VAI_VEC_OFFSET_ID  3'h3
// utility source levels
`define VAI_LVL_NONE       3'h0
`define VAI_LVL_LOW_ATT    3'h1
`define VAI_LVL_WATCH0     3'h2
`define VAI_LVL_IACK       3'h3
`define VAI_LVL_WATCH1     3'h4
`define VAI_LVL_HIGH_ATT   3'h5
`define VAI_LVL_SYSFAIL    3'h6
`define VAI_LVL_PWERR      3'h7
// reset values and bus answers
`define VAI_RST_BYTE       8'h00
`define VAI_RST_SYNC       8'hff
`define VAI_RESP_OKAY      2'h0
`define VAI_RESP_SLVERR    2'h2

`endif

// ===== common/vai_pkg.sv
// types shared by the address-modifier select and utility interrupt block
// assumes vai_defs.svh is on the include path
package vai_pkg;

    // one-cycle utility events from neighbouring logic, same clock
    typedef struct packed {
        logic posted_write_bus_error;
        logic high_attention_flag;
        logic location_watcher_1;
        logic ack_done;
        logic location_watcher_0;
        logic low_attention_flag;
    } vai_evt_t;

    // local cpu interrupt acknowledge, level from address lines a01-a03
    typedef struct packed {
        logic       valid;
        logic [2:0] level;
    } vai_ack_t;

    // utility interrupt request toward the local cpu
    typedef struct packed {
        logic       req;
        logic [2:0] level;
    } vai_irq_t;

    // read channel states
    typedef enum logic [1:0] {
        VAI_RD_IDLE = 2'b01,
        VAI_RD_RESP = 2'b10
    } vai_rd_state_t;

endpackage : vai_pkg

// ===== hdl/vai_top.sv
// address-modifier select, vme irq masking and utility interrupt handler
// assumes one 25 MHz clock, an AXI4-Lite master with 8-bit addresses,
// same-clock event pulses and asynchronous vme irq and sysfail pins
//
// Register access over AXI4-Lite was decided locally.
`include "vai_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module vai_top
    import vai_pkg::*;
(
    input  wire logic                  ref_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  sys_reset_in,
    input  wire logic [`VAI_AW-1:0]    s_axi_awaddr_in,
    input  wire logic                  s_axi_awvalid_in,
    output var  logic                  s_axi_awready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    input  wire logic                  s_axi_wvalid_in,
    output var  logic                  s_axi_wready_out,
    output var  logic [1:0]            s_axi_bresp_out,
    output var  logic                  s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    input  wire logic [`VAI_AW-1:0]    s_axi_araddr_in,
    input  wire logic                  s_axi_arvalid_in,
    output var  logic                  s_axi_arready_out,
    output var  logic [31:0]           s_axi_rdata_out,
    output var  logic [1:0]            s_axi_rresp_out,
    output var  logic                  s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    input  wire logic [5:0]            dyn_am_in,
    output var  logic [5:0]            am_out,
    input  wire logic [7:1]            vme_irq_n_in,
    input  wire logic                  sysfail_n_in,
    input  wire logic                  pc_global_enable_in,
    input  wire vai_evt_t              util_evt_in,
    input  wire vai_ack_t              cpu_ack_in,
    output var  logic [7:1]            vme_irq_pass_out,
    output var  vai_irq_t              util_irq_out,
    output var  logic [7:0]            vector_out,
    output var  logic                  vector_valid_out,
    output var  logic                  location_watcher_0_out,
    output var  logic [2:0]            irq_request_level_out
);

    // byte address of a printed register index
    function automatic logic [`VAI_AW-1:0] idx_byte(input logic [31:0] idx);
        idx_byte = {idx[`VAI_AW-3:0], 2'b00};
    endfunction : idx_byte

    // register select from a byte address, shared by read and write
    function automatic logic [2:0] reg_decode(input logic [`VAI_AW-1:0] a);
        if (a == idx_byte(`VAI_IDX_AM_SEL))
            reg_decode = `VAI_SEL_AM;
        else if (a == idx_byte(`VAI_IDX_VME_MASK))
            reg_decode = `VAI_SEL_VMASK;
        else if (a == idx_byte(`VAI_IDX_UTIL_MASK))
            reg_decode = `VAI_SEL_UMASK;
        else if (a == idx_byte(`VAI_IDX_UTIL_VEC))
            reg_decode = `VAI_SEL_VEC;
        else if (a == `VAI_ADDR_STATUS)
            reg_decode = `VAI_SEL_STATUS;
        else if (a == `VAI_ADDR_IRQ_LVL)
            reg_decode = `VAI_SEL_IRQ_LVL;
        else
            reg_decode = `VAI_SEL_NONE;
    endfunction : reg_decode

    // highest set level of a pending vector, none gives zero
    function automatic logic [2:0] top_level(input logic [7:1] v);
        top_level = `VAI_LVL_NONE;
        for (int i = 1; i <= 7; i++) begin
            if (v[i])
                top_level = 3'(i);
        end
    endfunction : top_level

    logic                  aw_have_reg;
    logic [`VAI_AW-1:0]    aw_addr_reg;
    logic                  w_have_reg;
    logic [7:0]            w_data_reg;
    logic                  w_lane0_reg;
    vai_rd_state_t         rd_state_reg;
    logic [7:0]            rd_byte_next;
    logic [2:0]            wr_sel;
    logic [2:0]            rd_sel;
    logic                  do_write;
    logic                  wr_en;
    logic                  am_src_reg;
    logic [5:0]            am_code_reg;
    logic [7:1]            vmask_reg;
    logic [7:1]            umask_reg;
    logic [7:3]            vbase_reg;
    logic [2:0]            ilvl_reg;
    logic [7:0]            sync1_reg;
    logic [7:0]            sync2_reg;
    logic [7:0]            sync3_reg;
    logic [7:0]            filt_reg;
    logic [7:1]            pend_reg;
    logic [7:1]            pend_next;
    logic [7:1]            util_set;
    logic [7:1]            util_clr;
    logic [7:1]            util_enabled;
    logic                  sysfail_act;

    // write channel: address and data taken in either order, held
    // until the response is taken so only one write is in flight
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aw_have_reg       <= 1'b0;
            aw_addr_reg       <= '0;
            s_axi_awready_out <= 1'b1;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_reg       <= 1'b1;
            aw_addr_reg       <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            aw_have_reg       <= 1'b0;
            s_axi_awready_out <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            w_have_reg       <= 1'b0;
            w_data_reg       <= `VAI_RST_BYTE;
            w_lane0_reg      <= 1'b0;
            s_axi_wready_out <= 1'b1;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_reg       <= 1'b1;
            w_data_reg       <= s_axi_wdata_in[7:0];
            w_lane0_reg      <= s_axi_wstrb_in[0];
            s_axi_wready_out <= 1'b0;
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            w_have_reg       <= 1'b0;
            s_axi_wready_out <= 1'b1;
        end
    end

    // registers are one byte wide, so only lane 0 stores anything
    assign wr_sel   = reg_decode(aw_addr_reg);
    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid_out;
    assign wr_en    = do_write && w_lane0_reg;

    // write response one cycle after both halves are held
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `VAI_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= (wr_sel == `VAI_SEL_NONE) ?
                                `VAI_RESP_SLVERR : `VAI_RESP_OKAY;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // read mux; vector low bits show the offset on a plain read
    assign rd_sel = reg_decode(s_axi_araddr_in);
    always_comb begin
        unique case (rd_sel)
            `VAI_SEL_AM:      rd_byte_next = {am_src_reg, 1'b0, am_code_reg};
            `VAI_SEL_VMASK:   rd_byte_next = {vmask_reg, 1'b0};
            `VAI_SEL_UMASK:   rd_byte_next = {umask_reg, 1'b0};
            `VAI_SEL_VEC:     rd_byte_next = {vbase_reg,
                                              `VAI_VEC_OFFSET_ID};
            `VAI_SEL_STATUS:  rd_byte_next = {pend_reg,
                                              location_watcher_0_out};
            `VAI_SEL_IRQ_LVL: rd_byte_next = {5'h00, ilvl_reg};
            default:          rd_byte_next = `VAI_RST_BYTE;
        endcase
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_state_reg    <= VAI_RD_IDLE;
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= `VAI_RESP_OKAY;
        end else begin
            unique case (rd_state_reg)
                VAI_RD_IDLE: begin
                    if (s_axi_arvalid_in) begin
                        rd_state_reg    <= VAI_RD_RESP;
                        s_axi_rdata_out <= {24'h000000, rd_byte_next};
                        s_axi_rresp_out <= (rd_sel == `VAI_SEL_NONE) ?
                                           `VAI_RESP_SLVERR : `VAI_RESP_OKAY;
                    end
                end
                VAI_RD_RESP: begin
                    if (s_axi_rready_in)
                        rd_state_reg <= VAI_RD_IDLE;
                end
                default: rd_state_reg <= VAI_RD_IDLE;
            endcase
        end
    end

    assign s_axi_arready_out = rd_state_reg[0];
    assign s_axi_rvalid_out  = rd_state_reg[1];

    // am select register, cleared by vme system reset
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            am_src_reg  <= 1'b0;
            am_code_reg <= 6'h00;
        end else if (sys_reset_in) begin
            am_src_reg  <= 1'b0;
            am_code_reg <= 6'h00;
        end else if (wr_en && wr_sel == `VAI_SEL_AM) begin
            am_src_reg  <= w_data_reg[`VAI_AM_SRC_BIT];
            am_code_reg <= w_data_reg[`VAI_AM_CODE_MSB:0];
        end
    end

    // am lines: stored code passes unscreened, reserved codes included
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            am_out <= 6'h00;
        else if (am_src_reg)
            am_out <= am_code_reg;
        else
            am_out <= dyn_am_in;
    end

    // mask and vector base registers, cleared by any reset
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vmask_reg <= 7'h00;
            umask_reg <= 7'h00;
            vbase_reg <= 5'h00;
        end else if (sys_reset_in) begin
            vmask_reg <= 7'h00;
            umask_reg <= 7'h00;
            vbase_reg <= 5'h00;
        end else if (wr_en) begin
            if (wr_sel == `VAI_SEL_VMASK)
                vmask_reg <= w_data_reg[7:1];
            if (wr_sel == `VAI_SEL_UMASK)
                umask_reg <= w_data_reg[7:1];
            if (wr_sel == `VAI_SEL_VEC)
                vbase_reg <= w_data_reg[7:`VAI_VEC_BASE_LSB];
        end
    end

    // interrupter request level; the iack answer beats a same-cycle write
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            ilvl_reg <= 3'h0;
        else if (sys_reset_in || util_evt_in.ack_done)
            ilvl_reg <= 3'h0;
        else if (wr_en && wr_sel == `VAI_SEL_IRQ_LVL)
            ilvl_reg <= w_data_reg[2:0];
    end

    assign irq_request_level_out = ilvl_reg;

    // pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_reg <= `VAI_RST_SYNC;
            sync2_reg <= `VAI_RST_SYNC;
            sync3_reg <= `VAI_RST_SYNC;
            filt_reg  <= `VAI_RST_SYNC;
        end else begin
            sync1_reg <= {sysfail_n_in, vme_irq_n_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= (sync2_reg & sync3_reg) |
                         (filt_reg & (sync2_reg ^ sync3_reg));
        end
    end

    // vme irq levels reach the cpu through mask and global enable
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            vme_irq_pass_out <= 7'h00;
        else
            vme_irq_pass_out <= ~filt_reg[6:0] & vmask_reg
                                & {7{pc_global_enable_in}};
    end

    // utility sources in level order; sysfail is a live level
    assign sysfail_act = ~filt_reg[7];
    assign util_set = {util_evt_in.posted_write_bus_error,
                       1'b0,
                       util_evt_in.high_attention_flag,
                       util_evt_in.location_watcher_1,
                       util_evt_in.ack_done,
                       util_evt_in.location_watcher_0,
                       util_evt_in.low_attention_flag};
    // a flag clears on cpu acknowledge of its level or a status write 1
    always_comb begin
        util_clr = 7'h00;
        if (cpu_ack_in.valid && cpu_ack_in.level != `VAI_LVL_NONE)
            util_clr[cpu_ack_in.level] = 1'b1;
        if (wr_en && wr_sel == `VAI_SEL_STATUS)
            util_clr = util_clr | w_data_reg[7:1];
    end

    // set beats clear so an event meeting its clear is not lost
    always_comb begin
        pend_next = util_set | (pend_reg & ~util_clr);
        pend_next[`VAI_LVL_SYSFAIL] = sysfail_act;
        if (sys_reset_in)
            pend_next = {1'b0, sysfail_act, 5'h00};
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_reg               <= 7'h00;
            location_watcher_0_out <= 1'b1;
        end else begin
            pend_reg               <= pend_next;
            location_watcher_0_out <= ~pend_next[`VAI_LVL_WATCH0];
        end
    end

    // request the highest enabled level; lower ones stay pending
    assign util_enabled = pend_reg & umask_reg;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            util_irq_out <= '0;
        end else begin
            util_irq_out.req   <= (|util_enabled) && pc_global_enable_in;
            util_irq_out.level <= top_level(util_enabled);
        end
    end

    // acknowledge vector: base bits over the cpu address lines
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vector_out       <= 8'h00;
            vector_valid_out <= 1'b0;
        end else begin
            vector_valid_out <= cpu_ack_in.valid;
            if (cpu_ack_in.valid)
                vector_out <= {vbase_reg, cpu_ack_in.level};
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    a_am_stored_drive: assert property (
        am_src_reg && !sys_reset_in |=> am_out == $past(am_code_reg))
        else $error("am lines differ from stored code");
    a_am_dynamic_drive: assert property (
        !am_src_reg |=> am_out == $past(dyn_am_in))
        else $error("am lines differ from dynamic code");
    a_am_sysreset_clear: assert property (
        sys_reset_in |=> !am_src_reg && am_code_reg == 6'h00)
        else $error("am register not cleared by system reset");
    a_vme_mask_gate: assert property (
        ##1 (vme_irq_pass_out & ~$past(vmask_reg)) == 7'h00)
        else $error("masked vme level passed");
    a_global_enable_gate: assert property (
        !pc_global_enable_in |=> vme_irq_pass_out == 7'h00 &&
                                 !util_irq_out.req)
        else $error("irq passed without global enable");
    a_mask_reset_clear: assert property (
        sys_reset_in |=> vmask_reg == 7'h00 && umask_reg == 7'h00 &&
                         vbase_reg == 5'h00)
        else $error("masks not cleared by reset");
    a_util_request_raise: assert property (
        (|util_enabled) && pc_global_enable_in |=> util_irq_out.req)
        else $error("enabled utility source gave no request");
    a_iack_done_pend: assert property (
        util_evt_in.ack_done && !sys_reset_in |=>
            pend_reg[`VAI_LVL_IACK] && irq_request_level_out == 3'h0)
        else $error("iack completion not recorded");
    a_sysfail_level_six: assert property (
        !sysfail_n_in [*4] |-> ##2 pend_reg[`VAI_LVL_SYSFAIL])
        else $error("sysfail low did not pend level 6");
    a_ack_vector_id: assert property (
        cpu_ack_in.valid |=> vector_valid_out &&
            vector_out[2:0] == $past(cpu_ack_in.level) &&
            vector_out[7:3] == $past(vbase_reg))
        else $error("acknowledge vector wrong");
    a_vec_read_offset: assert property (
        s_axi_arvalid_in && s_axi_arready_out &&
        rd_sel == `VAI_SEL_VEC |=>
            s_axi_rdata_out[2:0] == `VAI_VEC_OFFSET_ID)
        else $error("plain vector read low bits wrong");
    a_watcher0_flag_drop: assert property (
        util_evt_in.location_watcher_0 |=> !location_watcher_0_out)
        else $error("watcher 0 flag did not drop");
    a_top_level_first: assert property (
        util_enabled[`VAI_LVL_PWERR] |=>
            util_irq_out.level == `VAI_LVL_PWERR)
        else $error("highest level not presented");

    c_write_done: cover property (s_axi_bvalid_out && s_axi_bready_in);
    c_am_stored:  cover property (am_src_reg ##1 am_out != dyn_am_in);
    c_ack_cycle:  cover property (util_irq_out.req ##[1:8] vector_valid_out);
    c_sysfail:    cover property (util_enabled[`VAI_LVL_SYSFAIL]);

endmodule : vai_top

`default_nettype wire

// ===== verification/vai_cpu_model.sv
// cpu model: answers utility requests with an acknowledge cycle
// assumes the request is registered on the shared clock
`timescale 1ns/10ps
`default_nettype none
module vai_cpu_model import vai_pkg::*; (
    input  wire logic     ref_clk_in,
    input  wire logic     rstn_in,
    input  wire logic     en_in,
    input  wire logic     slow_in,
    input  wire vai_irq_t irq_in,
    output var  vai_ack_t ack_out
);
    logic [2:0] cnt_reg;
    // count down after an ack so a stale request is not taken twice
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_out <= '0;
            cnt_reg <= 3'h0;
        end else begin
            ack_out.valid <= (cnt_reg == 3'h4);
            // address lines carry the level only in the ack cycle
            ack_out.level <= (cnt_reg == 3'h4) ? irq_in.level
                                               : ~ack_out.level;
            if (cnt_reg != 3'h0)
                cnt_reg <= cnt_reg - 3'h1;
            else if (en_in && irq_in.req)
                cnt_reg <= slow_in ? 3'h7 : 3'h4;
        end
    end
endmodule : vai_cpu_model
`default_nettype wire

// ===== verification/vai_top_tb_top.sv
// bench: axi register traffic, vme pins, utility events and acks
// assumes vai_cpu_model stands for the local cpu
`timescale 1ns/10ps
`default_nettype none
module vai_top_tb_top import vai_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, sysr = 1'b0, gen = 1'b0, sysf_n = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic en = 1'b0, slow = 1'b0, awr, wrr, bv, arr, rv, vv, lw0;
    logic [7:0] awa = 8'h00, ara = 8'h00, b, vec;
    logic [31:0] wd = 32'h0, rdd;
    logic [5:0] dyn = 6'h00, c, am;
    logic [7:1] virq_n = 7'h7f, m, pass;
    logic [1:0] bresp, rresp;
    logic [2:0] ilvl;
    vai_evt_t evt = '0;
    vai_ack_t ack;
    vai_irq_t irq;
    int err_count = 0, n_compared = 0, cyc = 0;
    vai_top dut (.ref_clk_in(clk), .rstn_in(rstn), .sys_reset_in(sysr),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdd), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .dyn_am_in(dyn),
        .am_out(am), .vme_irq_n_in(virq_n), .sysfail_n_in(sysf_n),
        .pc_global_enable_in(gen), .util_evt_in(evt), .cpu_ack_in(ack),
        .vme_irq_pass_out(pass), .util_irq_out(irq), .vector_out(vec),
        .vector_valid_out(vv), .location_watcher_0_out(lw0),
        .irq_request_level_out(ilvl));
    vai_cpu_model cpu (.ref_clk_in(clk), .rstn_in(rstn), .en_in(en),
        .slow_in(slow), .irq_in(irq), .ack_out(ack));
    always #20 clk = ~clk;
    // a hang costs one mismatch and ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
        chk("bresp", er, bresp);
        repeat (2) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, d, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rry <= 1'b0;
        chk("rdata", {24'h0, d}, rdd);
        chk("rresp", er, rresp);
        // let an edge pass so the next call never reassigns rready at once
        @(posedge clk);
    endtask : rd
    task automatic regs0;
        for (int i = 0; i < 4; i++)
            rd(8'h34 + 8'(8 * i), (i == 3) ? 8'h03 : 8'h00, 2'h0);
    endtask : regs0
    task automatic vec_wait(input logic [7:0] e);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (vv !== 1'b1 && k < 40);
        chk("vector", {1'b1, e}, {vv, vec});
    endtask : vec_wait
    task automatic fire(input vai_evt_t e);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        // one more edge so outputs launched by the event have settled
        @(posedge clk);
    endtask : fire
    initial begin
        void'($urandom(97));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        regs0();
        rd(8'h00, 8'h00, 2'h2);
        // stored code goes out unchecked, or the master's own code
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 6'h3f : 6'($urandom);
            dyn <= 6'($urandom);
            wr(8'h34, {2'b10, c}, 2'h0);
            chk("am_stored", c, am);
            wr(8'h34, {2'b00, c}, 2'h0);
            chk("am_dynamic", dyn, am);
        end
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 7'h7f : 7'($urandom);
            virq_n <= (i == 1) ? 7'h00 : 7'($urandom);
            gen <= i[0];
            wr(8'h3c, {m, 1'b0}, 2'h0);
            repeat (8) @(posedge clk);
            chk("vme_pass", m & ~virq_n & {7{gen}}, pass);
        end
        b = 8'($urandom) & 8'hf8;
        wr(8'h4c, b, 2'h0);
        wr(8'h44, 8'hfe, 2'h0);
        wr(8'h54, 8'h03, 2'h0);
        chk("irq_level", 3'h3, ilvl);
        en <= 1'b1;
        // every source once, sysfail through its pin
        for (int l = 1; l < 8; l++) begin
            slow <= l[0];
            if (l == 6) sysf_n <= 1'b0;
            else fire(vai_evt_t'(6'h1 << ((l == 7) ? 5 : l - 1)));
            if (l == 2) chk("watch0_hit", 1'b0, lw0);
            vec_wait(b | 8'(l));
            sysf_n <= 1'b1;
            if (l == 2) chk("watch0_back", 1'b1, lw0);
            if (l == 3) chk("irq_level", 3'h0, ilvl);
            repeat (16) @(posedge clk);
        end
        en <= 1'b0;
        gen <= 1'b0;
        fire(6'h11);
        repeat (4) @(posedge clk);
        chk("req_off", 1'b0, irq.req);
        gen <= 1'b1;
        repeat (3) @(posedge clk);
        chk("req_high", 4'hd, irq);
        en <= 1'b1;
        vec_wait(b | 8'h05);
        vec_wait(b | 8'h01);
        wr(8'h44, 8'h00, 2'h0);
        fire(6'h08);
        repeat (6) @(posedge clk);
        chk("req_masked", 1'b0, irq.req);
        rd(8'h4c, b | 8'h03, 2'h0);
        wr(8'h34, 8'hbf, 2'h0);
        sysr <= 1'b1;
        @(posedge clk);
        sysr <= 1'b0;
        regs0();
        summarize();
    end
endmodule : vai_top_tb_top
`default_nettype wire
